// ### logic/aopc_top.sv
// adc output format and power configuration bank with serial data output
`timescale 1ns/1ns
`default_nettype none
module aopc_top
    import aopc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic ctrl_clk,
    input wire logic ctrl_sel_n,
    input wire logic ctrl_data,
    input wire logic shutdown_pin,
    input wire logic [WORD_W-1:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic [CHANNELS-1:0] lane_data,
    output logic [CHANNELS-1:0] lane_oe,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    output logic frame_clock_out,
    output logic frame_clock_oe,
    output logic [CHANNELS-1:0] chan_power_en,
    output logic reference_power_en,
    output logic [1:0] power_state,
    output logic [2:0] bit_clock_drive_code,
    output logic [2:0] frame_clock_drive_code,
    output logic [2:0] data_drive_code,
    output logic [6:0] bit_clock_drive_tenths,
    output logic [6:0] frame_clock_drive_tenths,
    output logic [6:0] data_drive_tenths,
    output logic [5:0] full_scale_fine,
    output logic [2:0] performance_ctrl,
    output logic [1:0] common_mode_buffer_strength,
    output logic [1:0] input_rate_sel
);
    // configuration registers
    logic [7:0] channel_sleep_bits_r;
    logic deep_sleep_bit_r;
    logic full_shutdown_bit_r;
    logic [1:0] shutdown_pin_mapping_r;
    logic [2:0] drv_bclk_r;
    logic [2:0] drv_frame_r;
    logic [2:0] drv_data_r;
    logic sdr_r;
    logic sdr_mid_r;
    logic twos_r;
    logic msb_first_r;
    logic [2:0] perf_r;
    logic [1:0] vcm_r;
    logic data_driver_sleep_mode_r;
    logic width14_r;
    logic advance_r;
    logic delay_r;
    logic [5:0] full_scale_fine_r;
    logic [1:0] rate_r;
    logic soft_rst_r;

    // control port
    logic wr_stb;
    logic [CTRL_ADDR_W-1:0] wr_addr;
    logic [CTRL_DATA_W-1:0] wr_data;

    aopc_ctrl_rx u_ctrl_rx (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .ctrl_clk(ctrl_clk),
        .ctrl_sel_n(ctrl_sel_n),
        .ctrl_data(ctrl_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    wire wr_rst = wr_stb && wr_addr == ADDR_SOFTWARE_RESET_CTRL;
    wire wr_pd = wr_stb && wr_addr == ADDR_POWER_DOWN_CTRL;
    wire wr_drv = wr_stb && wr_addr == ADDR_OUTPUT_DRIVE_CURRENT;
    wire wr_rate = wr_stb && wr_addr == ADDR_SERIAL_RATE_SELECT;
    wire wr_fmt = wr_stb && wr_addr == ADDR_SAMPLE_FORMAT_ORDER;
    wire wr_tune = wr_stb && wr_addr == ADDR_CONVERTER_TUNING;
    wire wr_sleep_w = wr_stb && wr_addr == ADDR_DRIVER_SLEEP_AND_WIDTH;
    wire wr_align = wr_stb && wr_addr == ADDR_WORD_ALIGNMENT_SHIFT;
    wire wr_fs = wr_stb && wr_addr == ADDR_FULL_SCALE_TRIM;
    wire wr_clkf = wr_stb && wr_addr == ADDR_INPUT_RATE_SELECT;
    // config clears on power-on reset and on the self-clearing soft reset
    wire cfg_clear = srst || soft_rst_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            soft_rst_r <= 1'b0;
        end else if (ce) begin
            soft_rst_r <= wr_rst && wr_data[RST_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (cfg_clear) begin
            channel_sleep_bits_r <= CH_SLEEP_RESET;
            deep_sleep_bit_r <= 1'b0;
            full_shutdown_bit_r <= 1'b0;
            shutdown_pin_mapping_r <= PIN_MAP_RESET;
        end else if (ce && wr_pd) begin
            channel_sleep_bits_r <= wr_data[CH_SLEEP_LSB +: 8];
            deep_sleep_bit_r <= wr_data[DEEP_SLEEP_BIT];
            full_shutdown_bit_r <= wr_data[FULL_PD_BIT];
            shutdown_pin_mapping_r <= wr_data[PIN_MAP_LSB +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (cfg_clear) begin
            drv_bclk_r <= DRV_CODE_RESET;
            drv_frame_r <= DRV_CODE_RESET;
            drv_data_r <= DRV_CODE_RESET;
        end else if (ce && wr_drv) begin
            drv_bclk_r <= wr_data[DRV_BCLK_LSB +: 3];
            drv_frame_r <= wr_data[DRV_FRAME_LSB +: 3];
            drv_data_r <= wr_data[DRV_DATA_LSB +: 3];
        end
    end

    always_ff @(posedge clock) begin
        if (cfg_clear) begin
            sdr_r <= 1'b0;
            sdr_mid_r <= 1'b0;
            twos_r <= 1'b0;
            msb_first_r <= 1'b0;
        end else if (ce) begin
            if (wr_rate) begin
                sdr_r <= wr_data[SDR_BIT];
                sdr_mid_r <= wr_data[SDR_MID_BIT];
            end
            if (wr_fmt) begin
                twos_r <= wr_data[TWOS_BIT];
                msb_first_r <= wr_data[MSB_FIRST_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (cfg_clear) begin
            perf_r <= PERF_RESET;
            vcm_r <= VCM_RESET;
            data_driver_sleep_mode_r <= 1'b0;
            width14_r <= 1'b0;
        end else if (ce) begin
            if (wr_tune) begin
                perf_r <= wr_data[PERF_LSB +: 3];
                vcm_r <= wr_data[VCM_LSB +: 2];
            end
            if (wr_sleep_w) begin
                data_driver_sleep_mode_r <= wr_data[DRV_SLEEP_BIT];
                width14_r <= wr_data[WIDTH14_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (cfg_clear) begin
            advance_r <= 1'b0;
            delay_r <= 1'b0;
            full_scale_fine_r <= FS_RESET;
            rate_r <= RATE_RESET;
        end else if (ce) begin
            if (wr_align) begin
                advance_r <= wr_data[ADVANCE_BIT];
                delay_r <= wr_data[DELAY_BIT];
            end
            if (wr_fs) begin
                full_scale_fine_r <= wr_data[FS_LSB +: 6];
            end
            if (wr_clkf) begin
                rate_r <= wr_data[RATE_LSB +: 2];
            end
        end
    end

    // power-down pin crosses in from a board-level signal
    logic pin_meta_r;
    logic pin_sync_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else if (ce) begin
            pin_meta_r <= shutdown_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    wire pin_chan = pin_sync_r && shutdown_pin_mapping_r[0];
    wire pin_deep = pin_sync_r && shutdown_pin_mapping_r == PIN_MAP_DEEP;
    wire pin_full = pin_sync_r && shutdown_pin_mapping_r == PIN_MAP_FULL;
    wire full_down = full_shutdown_bit_r || pin_full;
    wire deep_down = !full_down && (deep_sleep_bit_r || pin_deep);
    wire [7:0] chan_sleep = channel_sleep_bits_r | {8{pin_chan}};
    wire [CHANNELS-1:0] lane_sleep = chan_sleep | {CHANNELS{deep_down}};

    aopc_power_type power_now;

    always_comb begin
        if (full_down) begin
            power_now = PWR_FULL_DOWN;
        end else if (deep_down) begin
            power_now = PWR_DEEP_SLEEP;
        end else if (chan_sleep != '0) begin
            power_now = PWR_CHANNEL_SLEEP;
        end else begin
            power_now = PWR_ACTIVE;
        end
    end

    // sample buffer
    logic [WORD_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;

    aopc_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .in_data(sample_data),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // serializer: each bit lasts two clocks, phase 0 then phase 1
    logic phase_r;
    logic ddr_clk_r;
    logic [3:0] bit_idx_r;
    logic [WORD_W-1:0] word_r;
    logic [CHANNELS:0] hist1_r;
    logic [CHANNELS:0] hist2_r;

    wire [3:0] word_bits = width14_r ? BITS_WIDE : BITS_NARROW;
    wire bit_end = phase_r;
    wire word_end = bit_end && bit_idx_r >= word_bits - 4'h1;
    // pops only at word boundaries, so the fifo backs up when sampling outruns it
    assign fifo_pop = ce && word_end && fifo_valid;

    // picks the serial bit of one sample for the current bit slot
    function automatic logic pick_bit(input logic [SAMPLE_W-1:0] s, input logic [3:0] idx,
                                      input logic msb_first, input logic wide,
                                      input logic twos);
        logic [SAMPLE_W-1:0] v;
        logic [3:0] pos;
        v = twos ? {~s[SAMPLE_W-1], s[SAMPLE_W-2:0]} : s;
        // narrow words drop the two lowest bits
        if (msb_first) begin
            pos = 4'hd - idx;
        end else begin
            pos = wide ? idx : idx + 4'h2;
        end
        pick_bit = v[pos];
    endfunction

    logic [CHANNELS:0] stream_now;

    always_comb begin
        for (int n = 0; n < CHANNELS; n++) begin
            stream_now[n] = pick_bit(word_r[n*SAMPLE_W +: SAMPLE_W], bit_idx_r,
                                     msb_first_r, width14_r, twos_r);
        end
        stream_now[CHANNELS] = bit_idx_r < (word_bits >> 1);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            phase_r <= 1'b0;
            ddr_clk_r <= 1'b0;
            bit_idx_r <= '0;
            word_r <= '0;
            hist1_r <= '0;
            hist2_r <= '0;
        end else if (ce) begin
            phase_r <= !phase_r;
            if (!phase_r) begin
                ddr_clk_r <= !ddr_clk_r;
            end
            if (bit_end) begin
                hist1_r <= stream_now;
                hist2_r <= hist1_r;
                bit_idx_r <= word_end ? '0 : bit_idx_r + 4'h1;
            end
            if (word_end) begin
                // an empty buffer sends a zero word rather than stall the clocks
                word_r <= fifo_valid ? fifo_data : '0;
            end
        end
    end

    // tap: advance uses the live bit, delay the older one
    wire [CHANNELS:0] tap = (advance_r && !delay_r) ? stream_now :
                            (delay_r && !advance_r) ? hist2_r : hist1_r;
    wire clk_sdr = sdr_mid_r ? phase_r : !phase_r;
    wire clk_now = sdr_r ? clk_sdr : ddr_clk_r;

    logic [CHANNELS-1:0] lane_data_r;
    logic [CHANNELS-1:0] lane_oe_r;
    logic frame_r;
    logic bclk_r;
    logic clk_oe_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            lane_data_r <= '0;
            lane_oe_r <= '0;
            frame_r <= 1'b0;
            bclk_r <= 1'b0;
            clk_oe_r <= 1'b0;
        end else if (ce) begin
            lane_data_r <= tap[CHANNELS-1:0] & ~lane_sleep & {CHANNELS{!full_down}};
            lane_oe_r <= {CHANNELS{!full_down}} &
                         (~lane_sleep | {CHANNELS{data_driver_sleep_mode_r}});
            frame_r <= tap[CHANNELS] && !full_down;
            bclk_r <= clk_now && !full_down;
            clk_oe_r <= !full_down;
        end
    end

    assign lane_data = lane_data_r;
    assign lane_oe = lane_oe_r;
    assign bit_clock_out = bclk_r;
    assign bit_clock_oe = clk_oe_r;
    assign frame_clock_out = frame_r;
    assign frame_clock_oe = clk_oe_r;
    assign chan_power_en = ~lane_sleep & {CHANNELS{!full_down}};
    assign reference_power_en = !full_down;
    assign power_state = 2'(power_now);
    assign bit_clock_drive_code = drv_bclk_r;
    assign frame_clock_drive_code = drv_frame_r;
    assign data_drive_code = drv_data_r;
    assign bit_clock_drive_tenths = drive_tenths_ma(drv_bclk_r);
    assign frame_clock_drive_tenths = drive_tenths_ma(drv_frame_r);
    assign data_drive_tenths = drive_tenths_ma(drv_data_r);
    assign full_scale_fine = full_scale_fine_r;
    assign performance_ctrl = perf_r;
    assign common_mode_buffer_strength = vcm_r;
    assign input_rate_sel = rate_r;
endmodule // aopc_top
`default_nettype wire

// ### logic/aopc_pkg.sv
// shared constants and types for the adc output and power configuration block
package aopc_pkg;
    localparam int CHANNELS = 8;
    localparam int SAMPLE_W = 14;
    localparam int WORD_W = CHANNELS * SAMPLE_W;
    localparam int FIFO_DEPTH = 8;
    localparam int CTRL_ADDR_W = 8;
    localparam int CTRL_DATA_W = 16;
    localparam int CTRL_FRAME_BITS = CTRL_ADDR_W + CTRL_DATA_W;
    localparam logic [3:0] BITS_NARROW = 4'hc;
    localparam logic [3:0] BITS_WIDE = 4'he;
    // register offsets
    localparam logic [7:0] ADDR_SOFTWARE_RESET_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POWER_DOWN_CTRL = 8'h0f;
    localparam logic [7:0] ADDR_OUTPUT_DRIVE_CURRENT = 8'h11;
    localparam logic [7:0] ADDR_SERIAL_RATE_SELECT = 8'h40;
    localparam logic [7:0] ADDR_SAMPLE_FORMAT_ORDER = 8'h46;
    localparam logic [7:0] ADDR_CONVERTER_TUNING = 8'h50;
    localparam logic [7:0] ADDR_DRIVER_SLEEP_AND_WIDTH = 8'h52;
    localparam logic [7:0] ADDR_WORD_ALIGNMENT_SHIFT = 8'h53;
    localparam logic [7:0] ADDR_FULL_SCALE_TRIM = 8'h55;
    localparam logic [7:0] ADDR_INPUT_RATE_SELECT = 8'h56;
    // field positions
    localparam int RST_BIT = 0;
    localparam int CH_SLEEP_LSB = 0;
    localparam int DEEP_SLEEP_BIT = 8;
    localparam int FULL_PD_BIT = 9;
    localparam int PIN_MAP_LSB = 10;
    localparam int DRV_BCLK_LSB = 0;
    localparam int DRV_FRAME_LSB = 4;
    localparam int DRV_DATA_LSB = 8;
    localparam int SDR_BIT = 4;
    localparam int SDR_MID_BIT = 13;
    localparam int TWOS_BIT = 2;
    localparam int MSB_FIRST_BIT = 3;
    localparam int PERF_LSB = 0;
    localparam int VCM_LSB = 4;
    localparam int DRV_SLEEP_BIT = 0;
    localparam int WIDTH14_BIT = 1;
    localparam int ADVANCE_BIT = 4;
    localparam int DELAY_BIT = 5;
    localparam int FS_LSB = 0;
    localparam int RATE_LSB = 0;
    // reset values and shutdown pin mapping codes
    localparam logic [7:0] CH_SLEEP_RESET = 8'h00;
    localparam logic [1:0] PIN_MAP_RESET = 2'h0;
    localparam logic [2:0] DRV_CODE_RESET = 3'h0;
    localparam logic [5:0] FS_RESET = 6'h00;
    localparam logic [2:0] PERF_RESET = 3'h0;
    localparam logic [1:0] VCM_RESET = 2'h0;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [1:0] PIN_MAP_FULL = 2'h0;
    localparam logic [1:0] PIN_MAP_DEEP = 2'h2;

    typedef enum {PWR_ACTIVE, PWR_CHANNEL_SLEEP, PWR_DEEP_SLEEP, PWR_FULL_DOWN} aopc_power_type;

    // drive current in tenths of a milliampere for a 3-bit code
    function automatic logic [6:0] drive_tenths_ma(input logic [2:0] code);
        case (code)
            3'h0: drive_tenths_ma = 7'h23;
            3'h1: drive_tenths_ma = 7'h19;
            3'h2: drive_tenths_ma = 7'h0f;
            3'h3: drive_tenths_ma = 7'h05;
            3'h4: drive_tenths_ma = 7'h4b;
            3'h5: drive_tenths_ma = 7'h41;
            3'h6: drive_tenths_ma = 7'h37;
            default: drive_tenths_ma = 7'h2d;
        endcase
    endfunction
endpackage

// ### logic/aopc_fifo.sv
// sample fifo between the converter and the serializer
`timescale 1ns/1ns
`default_nettype none
module aopc_fifo #(
    parameter int WIDTH = 112,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count_r != (AW+1)'(DEPTH);
    assign out_valid = count_r != '0;
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge clock) begin
        if (ce && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // aopc_fifo
`default_nettype wire

// ### logic/aopc_ctrl_rx.sv
// serial control port receiver: 8-bit address then 16-bit data, msb first
`timescale 1ns/1ns
`default_nettype none
module aopc_ctrl_rx
    import aopc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic ctrl_clk,
    input wire logic ctrl_sel_n,
    input wire logic ctrl_data,
    output logic wr_stb,
    output logic [CTRL_ADDR_W-1:0] wr_addr,
    output logic [CTRL_DATA_W-1:0] wr_data
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic clk_prev_r;
    logic [4:0] count_r;
    logic [CTRL_FRAME_BITS-1:0] shift_r;
    logic stb_r;

    wire clk_rise = sync_r[0] && !clk_prev_r;
    wire sel_active = !sync_r[1];
    wire last_bit = count_r == 5'(CTRL_FRAME_BITS - 1);

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_r <= 3'h2;
            sync_r <= 3'h2;
            clk_prev_r <= 1'b0;
            count_r <= '0;
            shift_r <= '0;
            stb_r <= 1'b0;
        end else if (ce) begin
            meta_r <= {ctrl_data, ctrl_sel_n, ctrl_clk};
            sync_r <= meta_r;
            clk_prev_r <= sync_r[0];
            stb_r <= 1'b0;
            if (!sel_active) begin
                count_r <= '0;
            end else if (clk_rise) begin
                shift_r <= {shift_r[CTRL_FRAME_BITS-2:0], sync_r[2]};
                count_r <= last_bit ? '0 : count_r + 1'b1;
                stb_r <= last_bit;
            end
        end
    end

    assign wr_stb = stb_r;
    assign wr_addr = shift_r[CTRL_FRAME_BITS-1:CTRL_DATA_W];
    assign wr_data = shift_r[CTRL_DATA_W-1:0];
endmodule // aopc_ctrl_rx
`default_nettype wire

// ### verif/aopc_top_properties.sv
// concurrent checks on the power and output pins of the bank
`timescale 1ns/1ns
`default_nettype none
module aopc_top_properties (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic [1:0] power_state,
    input wire logic [7:0] chan_power_en,
    input wire logic reference_power_en,
    input wire logic [7:0] lane_data,
    input wire logic [7:0] lane_oe,
    input wire logic bit_clock_out,
    input wire logic bit_clock_oe,
    input wire logic frame_clock_oe,
    input wire logic [2:0] data_drive_code,
    input wire logic [6:0] data_drive_tenths
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // lane outputs are a registered image, so the state must hold a while
    sequence s_deep;
        (power_state == 2'h2 && ce) [*3];
    endsequence
    sequence s_down;
        (power_state == 2'h3 && ce) [*2];
    endsequence
    a_ref_power_off: assert property (reference_power_en == (power_state != 2'h3))
        else $error("reference power wrong");
    a_down_drivers_off: assert property (s_down |-> !bit_clock_oe && lane_oe == 8'h00)
        else $error("drivers on in power-down");
    a_deep_chans_off: assert property (power_state[1] |-> chan_power_en == 8'h00)
        else $error("channel powered in deep state");
    a_idle_all_on: assert property (power_state == 2'h0 |-> chan_power_en == 8'hff)
        else $error("channel off while active");
    a_light_sleep_some: assert property (power_state == 2'h1 |-> chan_power_en != 8'hff)
        else $error("light sleep with all channels on");
    a_sleep_clocks_on: assert property (power_state inside {2'h1, 2'h2} && ce |=>
        bit_clock_oe && frame_clock_oe) else $error("clock drivers off in sleep");
    a_deep_lanes_zero: assert property (s_deep |-> lane_data == 8'h00)
        else $error("lane data not zero in deep sleep");
    a_deep_clock_runs: assert property (s_deep |-> bit_clock_out != $past(bit_clock_out)
        || $past(bit_clock_out) != $past(bit_clock_out, 2)) else $error("bit clock stopped");
    a_drive_code_map: assert property ($stable(data_drive_code) |-> data_drive_tenths ==
        (data_drive_code[2] ? 7'h4b : 7'h23) - 7'h0a * data_drive_code[1:0])
        else $error("drive current map wrong");
endmodule // aopc_top_properties

bind aopc_top aopc_top_properties u_props (.*);
`default_nettype wire

// ### verif/aopc_link_rx.sv
// receiver model: counts bit clock rises in each frame clock period
`timescale 1ns/1ns
`default_nettype none
module aopc_link_rx (
    input wire logic clock,
    input wire logic bit_clock_out,
    input wire logic frame_clock_out,
    input wire logic frame_clock_oe,
    input wire logic [7:0] lane_data,
    output logic [8:0] frame_head,
    output logic [4:0] rises_per_frame,
    output logic [7:0] frame_cnt
);
    logic bclk_r = 1'b0;
    logic frame_clock_out_r = 1'b0;
    logic [4:0] cnt_r = 5'h00;
    logic [4:0] rises_r = 5'h00;
    logic [7:0] frames_r = 8'h00;
    assign rises_per_frame = rises_r;
    assign frame_cnt = frames_r;
    // a tristated frame clock carries no frames, so its edges are ignored
    always_ff @(posedge clock) begin
        bclk_r <= bit_clock_out;
        frame_clock_out_r <= frame_clock_out;
        if (frame_clock_oe && frame_clock_out && !frame_clock_out_r) begin
            rises_r <= cnt_r;
            frame_head <= {bit_clock_out, lane_data};
            cnt_r <= {4'h0, bit_clock_out && !bclk_r};
            frames_r <= frames_r + 8'h01;
        end else if (bit_clock_out && !bclk_r) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule // aopc_link_rx
`default_nettype wire

// ### verif/test_aopc_top.sv
// self-checking bench for the output format and power configuration bank
`timescale 1ns/1ns
`default_nettype none
module test_aopc_top
    import aopc_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic ctrl_clk = 1'b0;
    logic ctrl_sel_n = 1'b1;
    logic ctrl_data = 1'b0;
    logic shutdown_pin = 1'b0;
    logic [WORD_W-1:0] sample_data = 112'h0;
    logic sample_valid = 1'b0;
    logic sample_ready, bit_clock_out, bit_clock_oe, frame_clock_out, frame_clock_oe;
    logic reference_power_en, rdy, lvl;
    logic [7:0] lane_data, lane_oe, chan_power_en, frame_cnt, start;
    logic [1:0] power_state, common_mode_buffer_strength, input_rate_sel;
    logic [2:0] bit_clock_drive_code, frame_clock_drive_code, data_drive_code, performance_ctrl;
    logic [6:0] bit_clock_drive_tenths, frame_clock_drive_tenths, data_drive_tenths;
    logic [5:0] full_scale_fine;
    logic [4:0] rises_per_frame;
    logic [8:0] frame_head;
    logic [15:0] v;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    always #20 clock = ~clock;
    aopc_top uut (.*);
    aopc_link_rx u_rx (.*);
    function automatic logic [6:0] exp_tenths(input logic [2:0] c);
        return (c[2] ? 7'h4b : 7'h23) - 7'h0a * c[1:0];
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // control clock low 4 and high 4 cycles so the sampler sees every edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [23:0] f = {a, d};
        ctrl_sel_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            ctrl_data <= f[i];
            tick(4);
            ctrl_clk <= 1'b1;
            tick(4);
            ctrl_clk <= 1'b0;
        end
        ctrl_sel_n <= 1'b1;
        ctrl_data <= ~f[0];
        tick(6);
    endtask
    task automatic frame_rate(input string name, input logic [4:0] exp);
        start = frame_cnt;
        for (n = 0; n < 400 && frame_cnt - start < 8'h03; n++) tick(1);
        if (n == 400) begin
            error_cnt++;
            give_verdict();
        end
        check(name, {11'h0, exp}, {11'h0, rises_per_frame});
    endtask
    initial begin
        void'($urandom(57));
        tick(20);
        srst <= 1'b0;
        tick(2);
        check("reset codes", 16'h0, 16'({bit_clock_drive_code, data_drive_code}));
        check("reset tenths", 16'h0023, 16'(frame_clock_drive_tenths));
        check("reset trim", 16'h0, 16'(full_scale_fine));
        frame_rate("ddr 12 rises", 5'h06);
        for (int c = 0; c < 8; c++) begin
            v = {5'h0, 3'(c + 2), 1'b0, 3'(c + 1), 1'b0, 3'(c)};
            wr(ADDR_OUTPUT_DRIVE_CURRENT, v);
            check("bit clock ma", 16'(exp_tenths(v[2:0])), 16'(bit_clock_drive_tenths));
            check("frame ma", 16'(exp_tenths(v[6:4])), 16'(frame_clock_drive_tenths));
            check("data code", 16'(v[10:8]), 16'(data_drive_code));
        end
        v = 16'($urandom());
        wr(ADDR_FULL_SCALE_TRIM, v);
        wr(ADDR_CONVERTER_TUNING, v);
        wr(ADDR_INPUT_RATE_SELECT, v);
        wr(8'h01, 16'hffff);
        check("trim", 16'({v[5:0], v[5:4], v[2:0], v[1:0]}), 16'({full_scale_fine,
            common_mode_buffer_strength, performance_ctrl, input_rate_sel}));
        $display("test codes done");
        wr(ADDR_SERIAL_RATE_SELECT, 16'h0010);
        frame_rate("sdr 12 rises", 5'h0c);
        wr(ADDR_DRIVER_SLEEP_AND_WIDTH, 16'h0002);
        frame_rate("sdr 14 rises", 5'h0e);
        wr(ADDR_SERIAL_RATE_SELECT, 16'h0000);
        frame_rate("ddr 14 rises", 5'h07);
        wr(ADDR_SAMPLE_FORMAT_ORDER, 16'h000c);
        tick(90);
        check("msb head", 16'h00ff, 16'(frame_head[7:0]));
        lvl = frame_head[8];
        wr(ADDR_WORD_ALIGNMENT_SHIFT, 16'h0010);
        frame_rate("advance rises", 5'h07);
        check("advance head", {7'h0, ~lvl, 8'hff}, 16'(frame_head));
        wr(ADDR_WORD_ALIGNMENT_SHIFT, 16'h0020);
        tick(90);
        check("delay head", {7'h0, ~lvl, 8'hff}, 16'(frame_head));
        wr(ADDR_SERIAL_RATE_SELECT, 16'h2010);
        tick(90);
        check("mid head", 16'h00ff, 16'(frame_head));
        wr(ADDR_SERIAL_RATE_SELECT, 16'h0000);
        $display("test rates done");
        sample_valid <= 1'b1;
        n = 0;
        do begin
            sample_data <= 112'({$urandom(), $urandom(), $urandom(), $urandom()});
            @(negedge clock);
            rdy = sample_ready;
            n++;
            @(posedge clock);
        end while (rdy !== 1'b0 && n < 40);
        check("fifo full", 16'h0, 16'(rdy));
        if (rdy !== 1'b0) give_verdict();
        sample_valid <= 1'b0;
        tick(300);
        check("fifo drained", 16'h1, 16'(sample_ready));
        $display("test fifo done");
        v = {8'h00, 8'($urandom_range(254, 1))};
        wr(ADDR_POWER_DOWN_CTRL, v);
        check("light chans", {8'h0, ~v[7:0]}, 16'(chan_power_en));
        check("light state", 16'h1, 16'(power_state));
        wr(ADDR_DRIVER_SLEEP_AND_WIDTH, 16'h0001);
        wr(ADDR_POWER_DOWN_CTRL, 16'h0100);
        check("deep state", 16'h2, 16'(power_state));
        check("deep lanes on", 16'h00ff, 16'(lane_oe));
        frame_rate("deep rises", 5'h06);
        wr(ADDR_DRIVER_SLEEP_AND_WIDTH, 16'h0000);
        check("deep lanes off", 16'h0, 16'(lane_oe));
        wr(ADDR_POWER_DOWN_CTRL, 16'h0300);
        check("full state", 16'h3, 16'(power_state));
        check("full outputs", 16'h0, 16'({reference_power_en, bit_clock_oe, frame_clock_oe}));
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_POWER_DOWN_CTRL, 16'(m) << 10);
            shutdown_pin <= 1'b1;
            tick(5);
            check("pin state", 16'(m == 2 ? 2 : m % 2 ? 1 : 3), 16'(power_state));
            if (m % 2) check("pin chans", 16'h0, 16'(chan_power_en));
            shutdown_pin <= 1'b0;
            tick(5);
        end
        $display("test power done");
        wr(ADDR_FULL_SCALE_TRIM, 16'h002a);
        wr(ADDR_SOFTWARE_RESET_CTRL, 16'h0001);
        check("soft reset", 16'h0, 16'({full_scale_fine, data_drive_code}));
        wr(ADDR_FULL_SCALE_TRIM, 16'h0015);
        tick(8);
        check("trim after reset", 16'h0015, 16'(full_scale_fine));
        $display("test soft reset done");
        give_verdict();
    end
endmodule // test_aopc_top
`default_nettype wire
